// >>> sensor_link_pkg.sv
// Shared constants and types for the sensor serial slave
package sensor_link_pkg;

  // Pointer codes
  localparam logic [1:0] PTR_TEMP      = 2'h0;
  localparam logic [1:0] PTR_CFG       = 2'h1;
  localparam logic [1:0] PTR_HYS       = 2'h2;
  localparam logic [1:0] PTR_OVER      = 2'h3;
  localparam logic [1:0] PTR_RESET     = PTR_TEMP;

  // Reset values
  localparam logic [15:0] OVER_RESET   = 16'h5000;
  localparam logic [15:0] HYS_RESET    = 16'h4b00;
  localparam logic [4:0]  CFG_RESET    = 5'h00;

  // Configuration field positions
  localparam int CFG_W                 = 5;
  localparam int CFG_SD_BIT            = 0;
  localparam int CFG_MODE_BIT          = 1;
  localparam int CFG_POL_BIT           = 2;
  localparam int CFG_FT_LSB            = 3;
  localparam int CFG_FT_MSB            = 4;

  // Setpoint layout
  localparam int SIGN_BIT              = 15;
  localparam int TEMP_TOP_BIT          = 14;
  localparam int TRIP_W                = 9;
  localparam int TRIP_LSB              = 16 - TRIP_W;

  // Slave address
  localparam logic [3:0] ADDR_FIXED    = 4'h9;

  // Transfer unit timing in clock periods
  localparam logic [3:0] UNIT_DATA     = 4'h8;
  localparam logic [3:0] UNIT_ACK      = 4'h9;

  // Sync vector layout
  localparam int SYNC_W                = 7;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_RX       = 3'b011,
    ST_ACK_RX   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110
  } link_state_type;

endpackage

// >>> link_bit_capture.sv
// Serial clock domain: samples the data line on each rising clock edge
`timescale 1ns/1ps
module link_bit_capture (
  // Link clock and reset
  input  wire logic scl_clk,
  input  wire logic rst_n,
  // Data line
  input  wire logic sda_in,
  // Captured bit and event toggle
  output logic      bit_toggle,
  output logic      bit_value
);
  import sensor_link_pkg::*;

  typedef struct packed {
    logic toggle;
    logic value;
  } capture_state_type;

  capture_state_type cap_reg;
  capture_state_type cap_next;

  // One toggle per clock pulse, bit held for the whole period
  always_comb begin
    cap_next        = cap_reg;
    cap_next.toggle = ~cap_reg.toggle;
    cap_next.value  = sda_in;
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign bit_toggle = cap_reg.toggle;
  assign bit_value  = cap_reg.value;

endmodule

// >>> sync_two_stage.sv
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import sensor_link_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type sy_reg;
  sync_state_type sy_next;

  if (WIDTH < 1) begin
    $error("sync_two_stage width must be at least one");
  end

  always_comb begin
    sy_next        = sy_reg;
    sy_next.first  = async_in;
    sy_next.second = sy_reg.first;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign sync_out = sy_reg.second;

endmodule

// >>> sensor_serial_slave.sv
// Two-wire serial slave with pointer and alarm setpoint registers
//
// Function
// - Over-limit setpoint, 16-bit, resets to 80 degrees
// - Hysteresis setpoint, 16-bit, resets to 75 degrees
// - Setpoints: sign bit 15, top bit 14
// - Trip temperature uses upper nine bits only
// - Config resets: comparator, active-low, one fault
// - Pointer resets to temperature register
// - Unit: eight data bits plus acknowledge
// - Address 1001, straps, then direction bit
// - Data falling while clock high starts
// - Data rising while clock high stops
// - Receiver holds data low during ninth clock
// - Master not-acknowledge makes transmitter release line
// - First byte after write address loads pointer
// - Read without pointer write uses retained pointer
// - No limit on bytes per transfer
// - Config reads one byte, others two
// - Pointer 0 temp, 1 config, 2 hys, 3 over
`timescale 1ns/1ps
module sensor_serial_slave (
  // Core clock, reset and enable
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // Serial link
  input  wire logic                   scl_clk,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Address straps
  input  wire logic                   addr_strap_hi,
  input  wire logic                   addr_strap_mid,
  input  wire logic                   addr_strap_lo,
  // Conversion result
  input  wire logic [15:0]            temp_value,
  // Alarm thresholds, configuration and busy flag
  output logic [sensor_link_pkg::TRIP_W-1:0] over_limit_trip,
  output logic [sensor_link_pkg::TRIP_W-1:0] hysteresis_trip,
  output logic                        shutdown_mode,
  output logic                        alarm_interrupt_mode,
  output logic                        alarm_active_high,
  output logic [1:0]                  fault_queue_sel,
  output logic                        link_busy
);
  import sensor_link_pkg::*;

  typedef struct packed {
    link_state_type state;
    logic [3:0]     cnt;
    logic [7:0]     shift;
    logic           rw;
    logic           ptr_phase;
    logic [1:0]     ptr;
    logic           idx;
    logic [7:0]     hold;
    logic [7:0]     tx;
    logic [15:0]    over;
    logic [15:0]    hys;
    logic [CFG_W-1:0] cfg;
    logic           oe;
    logic           out;
    logic           scl_q;
    logic           sda_q;
    logic           tog_q;
    logic           ev_q;
    logic           busy;
  } core_state_type;

  core_state_type st_reg;
  core_state_type st_next;

  logic              link_toggle;
  logic              link_bit;
  logic [SYNC_W-1:0] sync_vec;
  logic              scl_s;
  logic              sda_s;
  logic              tog_s;
  logic              bit_s;
  logic [2:0]        strap_s;
  logic              start_ev;
  logic              stop_ev;
  logic              fall_ev;
  logic              bit_ev;
  logic              addr_hit;
  logic              commit_word;

  // Link domain bit capture
  link_bit_capture u_capture (
    .scl_clk    (scl_clk),
    .rst_n      (rst_n),
    .sda_in     (sda_in),
    .bit_toggle (link_toggle),
    .bit_value  (link_bit)
  );

  // Pins and link signals into core domain
  sync_two_stage #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({scl_clk, sda_in, link_toggle, link_bit,
                addr_strap_hi, addr_strap_mid, addr_strap_lo}),
    .sync_out (sync_vec)
  );

  assign scl_s   = sync_vec[6];
  assign sda_s   = sync_vec[5];
  assign tog_s   = sync_vec[4];
  assign bit_s   = sync_vec[3];
  assign strap_s = sync_vec[2:0];

  // Register read mux
  function automatic logic [7:0] read_byte(
    input logic [1:0]       p,
    input logic             i,
    input logic [15:0]      t,
    input logic [CFG_W-1:0] c,
    input logic [15:0]      h,
    input logic [15:0]      o
  );
    logic [15:0] word;
    word = t;
    unique case (p)
      PTR_TEMP: word = t;
      PTR_HYS:  word = h;
      PTR_OVER: word = o;
      PTR_CFG:  word = {{(8 - CFG_W){1'b0}}, c, 8'h00};
    endcase
    read_byte = i ? word[7:0] : word[15:8];
  endfunction

  // Bus conditions
  always_comb begin
    start_ev = clk_en && scl_s && st_reg.scl_q && st_reg.sda_q && !sda_s;
    stop_ev  = clk_en && scl_s && st_reg.scl_q && !st_reg.sda_q && sda_s;
    fall_ev  = clk_en && st_reg.scl_q && !scl_s;
    bit_ev   = clk_en && st_reg.ev_q;
    addr_hit = (st_reg.shift[7:4] == ADDR_FIXED) && (st_reg.shift[3:1] == strap_s);
    commit_word = (st_reg.state == ST_RX) && fall_ev && (st_reg.cnt == UNIT_DATA)
                  && !st_reg.ptr_phase && st_reg.idx
                  && ((st_reg.ptr == PTR_HYS) || (st_reg.ptr == PTR_OVER));
  end

  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.scl_q = scl_s;
      st_next.sda_q = sda_s;
      st_next.tog_q = tog_s;
      st_next.ev_q  = (tog_s != st_reg.tog_q);
      st_next.out   = 1'b0;
      if (bit_ev && (st_reg.cnt < UNIT_ACK)) begin
        st_next.shift = {st_reg.shift[6:0], bit_s};
        st_next.cnt   = st_reg.cnt + 4'h1;
      end
      if (stop_ev) begin
        st_next.state = ST_IDLE;
        st_next.oe    = 1'b0;
        st_next.cnt   = 4'h0;
      end else if (start_ev) begin
        st_next.state = ST_ADDR;
        st_next.oe    = 1'b0;
        st_next.cnt   = 4'h0;
        st_next.idx   = 1'b0;
      end else if (fall_ev) begin
        // Drive is set here, while the clock is low; start and stop above only release it
        unique case (st_reg.state)
          ST_IDLE: begin
            st_next.oe = 1'b0;
          end
          ST_ADDR: begin
            if (st_reg.cnt == UNIT_DATA) begin
              if (addr_hit) begin
                st_next.state = ST_ACK_ADDR;
                st_next.oe    = 1'b1;
                st_next.rw    = st_reg.shift[0];
              end else begin
                st_next.state = ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (st_reg.cnt == UNIT_ACK) begin
              st_next.cnt = 4'h0;
              if (st_reg.rw) begin
                // Retained pointer picks the register
                st_next.tx    = read_byte(st_reg.ptr, st_reg.idx, temp_value,
                                          st_reg.cfg, st_reg.hys, st_reg.over);
                st_next.oe    = ~st_next.tx[7];
                st_next.idx   = (st_reg.ptr == PTR_CFG) ? 1'b0 : ~st_reg.idx;
                st_next.state = ST_TX;
              end else begin
                st_next.oe        = 1'b0;
                st_next.ptr_phase = 1'b1;
                st_next.state     = ST_RX;
              end
            end
          end
          ST_RX: begin
            if (st_reg.cnt == UNIT_DATA) begin
              st_next.state = ST_ACK_RX;
              st_next.oe    = 1'b1;
              if (st_reg.ptr_phase) begin
                st_next.ptr       = st_reg.shift[1:0];
                st_next.idx       = 1'b0;
                st_next.ptr_phase = 1'b0;
              end else begin
                unique case (st_reg.ptr)
                  PTR_TEMP: begin
                    st_next.idx = 1'b0;
                  end
                  PTR_CFG: begin
                    st_next.cfg = st_reg.shift[CFG_W-1:0];
                  end
                  PTR_HYS, PTR_OVER: begin
                    if (!st_reg.idx) begin
                      st_next.hold = st_reg.shift;
                      st_next.idx  = 1'b1;
                    end else begin
                      st_next.idx = 1'b0;
                      if (st_reg.ptr == PTR_OVER) begin
                        st_next.over = {st_reg.hold, st_reg.shift};
                      end else begin
                        st_next.hys = {st_reg.hold, st_reg.shift};
                      end
                    end
                  end
                endcase
              end
            end
          end
          ST_ACK_RX: begin
            if (st_reg.cnt == UNIT_ACK) begin
              st_next.oe    = 1'b0;
              st_next.cnt   = 4'h0;
              st_next.state = ST_RX;
            end
          end
          ST_TX: begin
            if (st_reg.cnt == UNIT_DATA) begin
              st_next.oe    = 1'b0;
              st_next.state = ST_TX_ACK;
            end else begin
              st_next.tx = {st_reg.tx[6:0], 1'b0};
              st_next.oe = ~st_reg.tx[6];
            end
          end
          ST_TX_ACK: begin
            if (st_reg.cnt == UNIT_ACK) begin
              st_next.cnt = 4'h0;
              if (!st_reg.shift[0]) begin
                st_next.tx    = read_byte(st_reg.ptr, st_reg.idx, temp_value,
                                          st_reg.cfg, st_reg.hys, st_reg.over);
                st_next.oe    = ~st_next.tx[7];
                st_next.idx   = (st_reg.ptr == PTR_CFG) ? 1'b0 : ~st_reg.idx;
                st_next.state = ST_TX;
              end else begin
                st_next.oe    = 1'b0;
                st_next.state = ST_IDLE;
              end
            end
          end
          default: begin
            st_next.state = ST_IDLE;
            st_next.oe    = 1'b0;
          end
        endcase
      end
      st_next.busy = (st_next.state != ST_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.state     <= ST_IDLE;
      st_reg.ptr       <= PTR_RESET;
      st_reg.over      <= OVER_RESET;
      st_reg.hys       <= HYS_RESET;
      st_reg.cfg       <= CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from state
  assign sda_out              = st_reg.out;
  assign sda_oe               = st_reg.oe;
  assign over_limit_trip      = st_reg.over[SIGN_BIT:TRIP_LSB];
  assign hysteresis_trip      = st_reg.hys[SIGN_BIT:TRIP_LSB];
  assign shutdown_mode        = st_reg.cfg[CFG_SD_BIT];
  assign alarm_interrupt_mode = st_reg.cfg[CFG_MODE_BIT];
  assign alarm_active_high    = st_reg.cfg[CFG_POL_BIT];
  assign fault_queue_sel      = st_reg.cfg[CFG_FT_MSB:CFG_FT_LSB];
  assign link_busy            = st_reg.busy;

  // Checks
  a_over_write:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_reg.over != $past(st_reg.over)) |-> $past(commit_word && st_reg.ptr == PTR_OVER))
  else $error("over-limit setpoint changed without a word write");

  a_hys_write:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_reg.hys != $past(st_reg.hys)) |-> $past(commit_word && st_reg.ptr == PTR_HYS))
  else $error("hysteresis setpoint changed without a word write");

  a_trip_upper:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    commit_word && st_reg.ptr == PTR_OVER
      |=> over_limit_trip == {$past(st_reg.hold), $past(st_reg.shift[7])})
  else $error("trip value not taken from upper nine bits");

  a_addr_ack:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    fall_ev && !start_ev && !stop_ev && st_reg.state == ST_ADDR && st_reg.cnt == UNIT_DATA && addr_hit
      |=> sda_oe && st_reg.state == ST_ACK_ADDR)
  else $error("matched address not acknowledged");

  a_addr_miss:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    fall_ev && !start_ev && !stop_ev && st_reg.state == ST_ADDR && st_reg.cnt == UNIT_DATA && !addr_hit
      |=> !sda_oe && st_reg.state == ST_IDLE)
  else $error("foreign address acknowledged");

  a_rx_ack_low:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_reg.state == ST_ACK_RX || st_reg.state == ST_ACK_ADDR) |-> sda_oe)
  else $error("receiver acknowledge not driven");

  a_nack_release:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    fall_ev && !start_ev && !stop_ev && st_reg.state == ST_TX_ACK && st_reg.cnt == UNIT_ACK && st_reg.shift[0]
      |=> !sda_oe && st_reg.state == ST_IDLE)
  else $error("data line not released after not-acknowledge");

  a_start_addr:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    start_ev |=> st_reg.state == ST_ADDR && st_reg.cnt == 4'h0 && !sda_oe)
  else $error("start condition not taken");

  a_stop_idle:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_ev |=> st_reg.state == ST_IDLE && !sda_oe)
  else $error("stop condition not taken");

  a_drive_low_clk:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (sda_oe != $past(sda_oe)) |-> $past(fall_ev || start_ev || stop_ev))
  else $error("data drive changed while clock high");

  a_ptr_load:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_reg.ptr != $past(st_reg.ptr)) |-> $past(st_reg.state == ST_RX && st_reg.ptr_phase && fall_ev))
  else $error("pointer changed outside pointer byte");

  a_unit_nine:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_reg.state == ST_ADDR || st_reg.state == ST_RX || st_reg.state == ST_TX) |-> st_reg.cnt <= UNIT_DATA)
  else $error("data phase longer than eight clocks");

endmodule

// >>> wire_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data line
`timescale 1ns/1ps
module wire_master_model (
  // Serial clock, stands high outside frames
  output logic      scl,
  // Data line pull-down request and wire level
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // One bit: data set in low phase, sampled in high phase
  task automatic bit_cycle(input logic b, output logic r);
    #10 sda_low = ~b;
    #40 scl = 1'b1;
    #15 r = sda;
    #15 scl = 1'b0;
  endtask

  // Start from idle or as a repeated start
  task automatic start_cond();
    #10 sda_low = 1'b0;
    #40 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask

  // Stop, then the bus stays idle with the clock high
  task automatic stop_cond();
    #10 sda_low = 1'b1;
    #40 scl = 1'b1;
    #100 sda_low = 1'b0;
    #200;
  endtask

  // Eight data bits then the acknowledge bit, no gap between units
  task automatic unit(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
      q[i] = r;
    end
    bit_cycle(ack_bit, ack_seen);
  endtask
endmodule

// >>> tb_top.sv
// Self-checking testbench for the sensor serial slave
`timescale 1ns/1ps
module tb_top;
  import sensor_link_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic              clk_en;
  logic              scl_clk;
  logic              sda_low;
  logic              sda_out;
  logic              sda_oe;
  logic [2:0]        strap;
  logic [15:0]       temp_value;
  logic [TRIP_W-1:0] over_limit_trip;
  logic [TRIP_W-1:0] hysteresis_trip;
  logic              shutdown_mode;
  logic              alarm_interrupt_mode;
  logic              alarm_active_high;
  logic [1:0]        fault_queue_sel;
  logic              link_busy;
  logic [31:0]       seed;
  logic [15:0]       o;
  logic [15:0]       h;
  int                failures;
  int                checks;
  wire               sda = ~((sda_oe & ~sda_out) | sda_low);

  sensor_serial_slave DUT (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_clk(scl_clk), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(strap[2]), .addr_strap_mid(strap[1]),
    .addr_strap_lo(strap[0]), .temp_value(temp_value), .over_limit_trip(over_limit_trip),
    .hysteresis_trip(hysteresis_trip), .shutdown_mode(shutdown_mode),
    .alarm_interrupt_mode(alarm_interrupt_mode), .alarm_active_high(alarm_active_high),
    .fault_queue_sel(fault_queue_sel), .link_busy(link_busy)
  );

  wire_master_model m (.scl(scl_clk), .sda_low(sda_low), .sda(sda));

  always #4 core_clk = ~core_clk;

  function automatic logic [15:0] roll();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  function automatic logic [15:0] trip_of(input logic [15:0] v);
    return {7'h00, v[15:7]};
  endfunction

  function automatic logic [7:0] cfg_of(input logic [7:0] b);
    return {3'h0, b[4:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Byte to the device, acknowledge expected
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    m.unit(d, 1'b1, q, a);
    check("ack", {15'h0000, a}, 16'h0000);
  endtask

  // Byte from the device, acknowledged unless last
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] q;
    logic       a;
    m.unit(8'hff, last, q, a);
    check("read byte", {8'h00, q}, {8'h00, exp});
  endtask

  task automatic open(input logic rw);
    m.start_cond();
    send({ADDR_FIXED, strap, rw});
  endtask

  task automatic write_reg(input logic [1:0] ptr, input logic [15:0] v, input int n);
    open(1'b0);
    send({6'h00, ptr});
    if (n > 1) send(v[15:8]);
    send(v[7:0]);
    m.stop_cond();
  endtask

  // Read of a word through the retained pointer, then release after the last byte
  task automatic read_word(input logic [15:0] v);
    open(1'b1);
    check("busy", {15'h0000, link_busy}, 16'h0001);
    recv(1'b0, v[15:8]);
    recv(1'b1, v[7:0]);
    #60 check("release", {15'h0000, sda_oe}, 16'h0000);
    check("idle after nack", {15'h0000, link_busy}, 16'h0000);
    m.stop_cond();
  endtask

  task automatic reset_dut();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    check("over reset", {7'h00, over_limit_trip}, trip_of(16'h5000));
    check("hys reset", {7'h00, hysteresis_trip}, trip_of(16'h4b00));
    check("config reset", {11'h000, fault_queue_sel, alarm_active_high, alarm_interrupt_mode, shutdown_mode},
          16'h0000);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask

  initial begin
    #600000;
    failures++;
    final_report();
  end

  initial begin
    logic [7:0] q;
    logic       a;
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    strap      = 3'h0;
    temp_value = 16'h0000;
    seed       = 32'h2be50e3a;
    failures   = 0;
    checks     = 0;
    @(posedge core_clk);
    o          = roll();
    strap      <= o[2:0];
    temp_value <= {o[15:7], 7'h00};
    reset_dut();
    // Retained pointer after reset selects temperature
    read_word(temp_value);
    // Wrong fixed nibble and wrong straps are not acknowledged
    for (int k = 0; k < 2; k++) begin
      m.start_cond();
      m.unit(k == 0 ? {4'h8, strap, 1'b0} : {ADDR_FIXED, strap ^ 3'h1, 1'b0}, 1'b1, q, a);
      check("nack", {15'h0000, a}, 16'h0001);
      m.stop_cond();
    end
    // Setpoint writes, trip outputs and read-back
    for (int i = 0; i < 4; i++) begin
      o = roll();
      h = roll();
      if (i == 0) begin
        o = 16'hff80;
        h = 16'h007f;
      end
      write_reg(PTR_OVER, o, 2);
      write_reg(PTR_HYS, h, 2);
      check("over trip", {7'h00, over_limit_trip}, trip_of(o));
      check("hys trip", {7'h00, hysteresis_trip}, trip_of(h));
      read_word(h);
      open(1'b0);
      send({6'h00, PTR_OVER});
      open(1'b1);
      recv(1'b0, o[15:8]);
      recv(1'b0, o[7:0]);
      recv(1'b0, o[15:8]);
      recv(1'b1, o[7:0]);
      m.stop_cond();
    end
    // Configuration write and single-byte read
    for (int i = 0; i < 2; i++) begin
      o = roll();
      if (i == 0) o[7:0] = 8'hff;
      write_reg(PTR_CFG, {8'h00, o[7:0]}, 1);
      check("config", {11'h000, fault_queue_sel, alarm_active_high, alarm_interrupt_mode, shutdown_mode},
            {11'h000, o[4:0]});
      open(1'b0);
      send({6'h00, PTR_CFG});
      open(1'b1);
      recv(1'b0, cfg_of(o[7:0]));
      recv(1'b1, cfg_of(o[7:0]));
      m.stop_cond();
    end
    // Pointer back to temperature, then reset mid-run
    // Frozen core ignores a matching address
    @(posedge core_clk);
    clk_en <= 1'b0;
    m.start_cond();
    m.unit({ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
    check("frozen ack", {15'h0000, a}, 16'h0001);
    m.stop_cond();
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    o = roll();
    @(posedge core_clk);
    temp_value <= o;
    open(1'b0);
    send({6'h00, PTR_TEMP});
    m.stop_cond();
    read_word(o);
    write_reg(PTR_OVER, 16'h1234, 2);
    reset_dut();
    read_word(o);
    final_report();
  end
endmodule
